/* File: design/tcc_pkg.sv */
// constants, field positions and carrier types for the timer control and capture block
// assumes a 32-bit apb master and a single 250 mhz system clock
package tcc_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses (address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_MATCH_LO = 16'h7F18; // lower match data
  localparam logic [15:0] IDX_MATCH_HI = 16'h7F19; // upper match data
  localparam logic [15:0] IDX_COUNT_LO = 16'h7F1A; // lower count byte
  localparam logic [15:0] IDX_COUNT_HI = 16'h7F1B; // upper count byte
  localparam logic [15:0] IDX_RUN_FLAG = 16'h7F1C; // run and flag control
  localparam logic [15:0] IDX_CAPTURE = 16'h7F1D; // capture control
  localparam logic [15:0] IDX_CLK_PRE = 16'h7F1E; // clock and prescale control
  localparam logic [31:0] ADDR_MATCH_LO = {14'h0000, IDX_MATCH_LO, 2'h0};
  localparam logic [31:0] ADDR_MATCH_HI = {14'h0000, IDX_MATCH_HI, 2'h0};
  localparam logic [31:0] ADDR_COUNT_LO = {14'h0000, IDX_COUNT_LO, 2'h0};
  localparam logic [31:0] ADDR_COUNT_HI = {14'h0000, IDX_COUNT_HI, 2'h0};
  localparam logic [31:0] ADDR_RUN_FLAG = {14'h0000, IDX_RUN_FLAG, 2'h0};
  localparam logic [31:0] ADDR_CAPTURE = {14'h0000, IDX_CAPTURE, 2'h0};
  localparam logic [31:0] ADDR_CLK_PRE = {14'h0000, IDX_CLK_PRE, 2'h0};

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00; // every register resets to zero
  localparam logic [3:0] RST_PRE = 4'h0; // prescaler count after reset
  localparam logic [7:0] CAPTURE_MASK = 8'h1F; // bits 7..5 read zero
  localparam logic [7:0] CLK_PRE_MASK = 8'hEF; // bit 4 reads zero

  // ----------------------------------------------------------------
  // field positions of run_flag_control
  // ----------------------------------------------------------------
  localparam int unsigned RF_UPPER_RUN = 7;
  localparam int unsigned RF_UPPER_FLAG = 6;
  localparam int unsigned RF_UPPER_IE = 5;
  localparam int unsigned RF_SPLIT = 4;
  localparam int unsigned RF_CAP_READ = 3;
  localparam int unsigned RF_MAIN_RUN = 2;
  localparam int unsigned RF_MAIN_FLAG = 1;
  localparam int unsigned RF_MAIN_IE = 0;

  // ----------------------------------------------------------------
  // field positions of capture_control and clock_prescale_control
  // ----------------------------------------------------------------
  localparam int unsigned CC_SRC_HI = 4;
  localparam int unsigned CC_SRC_LO = 3;
  localparam int unsigned CC_UPPER_FLAG = 2;
  localparam int unsigned CC_LOWER_FLAG = 1;
  localparam int unsigned CC_IE = 0;
  localparam int unsigned CP_CLK_HI = 7;
  localparam int unsigned CP_CLK_LO = 6;
  localparam int unsigned CP_EVENT_SEL = 5;
  localparam int unsigned CP_PRE_HI = 3;
  localparam int unsigned CP_PRE_LO = 0;

  // ----------------------------------------------------------------
  // clock source codes and input bit positions
  // ----------------------------------------------------------------
  localparam logic [1:0] CKSEL_SYSTEM = 2'h0;
  localparam logic [1:0] CKSEL_EVENT = 2'h1;
  localparam logic [1:0] CKSEL_AUX_A = 2'h2;
  localparam logic [1:0] CKSEL_AUX_B = 2'h3;
  localparam int unsigned IN_AUX_A = 6; // position of aux oscillator a in the sampled vector
  localparam int unsigned IN_AUX_B = 7; // position of aux oscillator b
  localparam int unsigned IN_WIDTH = 8; // six external lines plus two oscillators

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } tcc_apb_req_t;

  typedef struct packed {
    logic aux_oscillator_b;
    logic aux_oscillator_a;
    logic [5:0] ext_line; // ext_line_zero .. ext_line_five
  } tcc_pins_t;

endpackage : tcc_pkg

/* File: design/tcc_timer.sv */
// timer with 16-bit or dual 8-bit operation, capture, prescaler and apb registers
// assumes a zero-wait apb master on clock_i and asynchronous pin inputs
//
// Summary of operation
// - upper byte counts on overflow or prescale tick
// - read select swaps counters for capture bytes
// - split mode upper run low holds upper counter zero
// - upper flag set at zero in split mode, software clears
// - split mode upper enable and flag request
// - split bit picks 16-bit or dual 8-bit
// - main run low holds timer at zero
// - main flag set at zero, software clears
// - main enable and flag raise request
// - source field picks lower capture line
// - upper capture lines depend on mode
// - upper capture flag set only split mode
// - lower capture flag set on lower update
// - capture enable with either flag requests
// - clock field picks prescaler count clock
// - event select picks line two or three
// - prescale period is field plus one
// - match buffer reloads at zero, follows stopped
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module tcc_timer (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire tcc_pkg::tcc_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire tcc_pkg::tcc_pins_t pins_i,
  output logic irq_req_o
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and rising edge detect
  // ----------------------------------------------------------------
  logic [IN_WIDTH-1:0] raw_in; // all pin inputs in one vector
  logic [IN_WIDTH-1:0] sync1_r; // first stage, read only by sync2_r
  logic [IN_WIDTH-1:0] sync2_r; // second stage
  logic [IN_WIDTH-1:0] prev_r; // delayed copy for edges
  logic [IN_WIDTH-1:0] rise; // one-cycle rising edge pulses

  assign raw_in = pins_i;

  genvar gi;
  generate
    for (gi = 0; gi < IN_WIDTH; gi = gi + 1) begin : g_sync
      // two flops then an edge register per input
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi] <= sync2_r[gi];
        end
      end
      assign rise[gi] = sync2_r[gi] & ~prev_r[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] match_lo_r, match_lo_nxt; // lower_match_data
  logic [7:0] match_hi_r, match_hi_nxt; // upper_match_data
  logic [7:0] run_flag_r, run_flag_nxt; // run_flag_control
  logic [7:0] capture_r, capture_nxt; // capture_control
  logic [7:0] clk_pre_r, clk_pre_nxt; // clock_prescale_control
  logic [7:0] count_lo_r, count_lo_nxt; // lower_count_byte
  logic [7:0] count_hi_r, count_hi_nxt; // upper_count_byte
  logic [7:0] buf_lo_r, buf_lo_nxt; // lower match buffer
  logic [7:0] buf_hi_r, buf_hi_nxt; // upper match buffer
  logic [7:0] cap_lo_r, cap_lo_nxt; // lower_capture_byte
  logic [7:0] cap_hi_r, cap_hi_nxt; // upper_capture_byte
  logic [3:0] pre_cnt_r, pre_cnt_nxt; // prescaler counter
  logic [31:0] prdata_r, prdata_nxt; // registered read data

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup_w = apb_i.psel & ~apb_i.penable; // first cycle of a transfer
  wire access_w = apb_i.psel & apb_i.penable; // completing cycle
  wire wr_w = access_w & apb_i.pwrite; // write takes effect now
  wire [7:0] wd = apb_i.pwdata[7:0]; // byte written
  wire hit_match_lo = apb_i.paddr == ADDR_MATCH_LO;
  wire hit_match_hi = apb_i.paddr == ADDR_MATCH_HI;
  wire hit_count_lo = apb_i.paddr == ADDR_COUNT_LO;
  wire hit_count_hi = apb_i.paddr == ADDR_COUNT_HI;
  wire hit_run_flag = apb_i.paddr == ADDR_RUN_FLAG;
  wire hit_capture = apb_i.paddr == ADDR_CAPTURE;
  wire hit_clk_pre = apb_i.paddr == ADDR_CLK_PRE;
  wire mapped_w = hit_match_lo | hit_match_hi | hit_count_lo | hit_count_hi |
                  hit_run_flag | hit_capture | hit_clk_pre;
  wire wr_run_flag = wr_w & hit_run_flag;
  wire wr_capture = wr_w & hit_capture;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire upper_run_bit = run_flag_r[RF_UPPER_RUN];
  wire upper_match_flag = run_flag_r[RF_UPPER_FLAG];
  wire upper_irq_enable = run_flag_r[RF_UPPER_IE];
  wire split_mode_bit = run_flag_r[RF_SPLIT];
  wire capture_read_select = run_flag_r[RF_CAP_READ];
  wire main_run_bit = run_flag_r[RF_MAIN_RUN];
  wire main_match_flag = run_flag_r[RF_MAIN_FLAG];
  wire main_irq_enable = run_flag_r[RF_MAIN_IE];
  wire [1:0] capture_source_select = capture_r[CC_SRC_HI:CC_SRC_LO];
  wire upper_capture_flag = capture_r[CC_UPPER_FLAG];
  wire lower_capture_flag = capture_r[CC_LOWER_FLAG];
  wire capture_irq_enable = capture_r[CC_IE];
  wire [1:0] clock_source_select = clk_pre_r[CP_CLK_HI:CP_CLK_LO];
  wire event_line_select = clk_pre_r[CP_EVENT_SEL];
  wire [3:0] prescale_period = clk_pre_r[CP_PRE_HI:CP_PRE_LO];

  // ----------------------------------------------------------------
  // prescaler and count clocks
  // ----------------------------------------------------------------
  wire event_tick = event_line_select ? rise[3] : rise[2];
  wire count_tick = (clock_source_select == CKSEL_SYSTEM) ? 1'b1 :
                    (clock_source_select == CKSEL_EVENT) ? event_tick :
                    (clock_source_select == CKSEL_AUX_A) ? rise[IN_AUX_A] :
                    rise[IN_AUX_B];
  wire pre_run = main_run_bit | (split_mode_bit & upper_run_bit); // prescaler runs for either byte
  wire pre_match = pre_run & count_tick & (pre_cnt_r == prescale_period);
  // low byte takes events straight in split event mode
  wire lo_tick = (split_mode_bit & (clock_source_select == CKSEL_EVENT)) ? event_tick : pre_match;

  // prescaler count, cleared when stopped or at its match
  assign pre_cnt_nxt = !pre_run ? RST_PRE :
                       !count_tick ? pre_cnt_r :
                       pre_match ? RST_PRE : 4'(pre_cnt_r + 4'h1);

  // ----------------------------------------------------------------
  // counters and match logic
  // ----------------------------------------------------------------
  wire lo_run = main_run_bit;
  wire hi_run = split_mode_bit ? upper_run_bit : main_run_bit;
  wire lo_equal = split_mode_bit ? (count_lo_r == buf_lo_r) :
                  ({count_hi_r, count_lo_r} == {buf_hi_r, buf_lo_r}); // all 16 bits in full mode
  wire lo_match = lo_run & lo_tick & lo_equal;
  wire lo_ovf = lo_run & lo_tick & ~lo_match & (count_lo_r == 8'hFF);
  wire hi_tick = split_mode_bit ? pre_match : lo_ovf;
  wire hi_match = split_mode_bit ? (hi_run & hi_tick & (count_hi_r == buf_hi_r)) : lo_match;

  // lower byte: zero when stopped or matched, else count
  assign count_lo_nxt = (!lo_run | lo_match) ? RST_BYTE :
                        lo_tick ? 8'(count_lo_r + 8'h01) : count_lo_r;
  // upper byte: same scheme on its own tick
  assign count_hi_nxt = (!hi_run | hi_match) ? RST_BYTE :
                        hi_tick ? 8'(count_hi_r + 8'h01) : count_hi_r;
  // buffers track match data while stopped, reload at zero
  assign buf_lo_nxt = (!lo_run | lo_match) ? match_lo_r : buf_lo_r;
  assign buf_hi_nxt = (!hi_run | hi_match) ? match_hi_r : buf_hi_r;

  // ----------------------------------------------------------------
  // capture requests
  // ----------------------------------------------------------------
  wire lo_req = (capture_source_select == 2'h0) ? rise[0] :
                (capture_source_select == 2'h1) ? rise[2] :
                (capture_source_select == 2'h2) ? rise[4] : rise[5];
  wire hi_req_split = (capture_source_select == 2'h0) ? rise[1] :
                      (capture_source_select == 2'h1) ? rise[3] :
                      (capture_source_select == 2'h2) ? rise[5] : rise[4];
  wire hi_req = split_mode_bit ? hi_req_split : lo_req;

  assign cap_lo_nxt = lo_req ? count_lo_r : cap_lo_r;
  assign cap_hi_nxt = hi_req ? count_hi_r : cap_hi_r;

  // ----------------------------------------------------------------
  // flag set terms and software clear terms
  // ----------------------------------------------------------------
  wire set_main_flag = lo_match;
  wire set_upper_flag = split_mode_bit & hi_match;
  wire set_lower_cap = lo_req;
  wire set_upper_cap = split_mode_bit & hi_req;
  wire clr_main_flag = wr_run_flag & ~wd[RF_MAIN_FLAG];
  wire clr_upper_flag = wr_run_flag & ~wd[RF_UPPER_FLAG];
  wire clr_lower_cap = wr_capture & ~wd[CC_LOWER_FLAG];
  wire clr_upper_cap = wr_capture & ~wd[CC_UPPER_FLAG];

  // run_flag_control next value, set wins over clear
  always_comb begin
    run_flag_nxt = wr_run_flag ? wd : run_flag_r;
    run_flag_nxt[RF_MAIN_FLAG] = set_main_flag | (main_match_flag & ~clr_main_flag);
    run_flag_nxt[RF_UPPER_FLAG] = set_upper_flag | (upper_match_flag & ~clr_upper_flag);
  end

  // capture_control next value, reserved bits kept zero
  always_comb begin
    capture_nxt = wr_capture ? (wd & CAPTURE_MASK) : capture_r;
    capture_nxt[CC_LOWER_FLAG] = set_lower_cap | (lower_capture_flag & ~clr_lower_cap);
    capture_nxt[CC_UPPER_FLAG] = set_upper_cap | (upper_capture_flag & ~clr_upper_cap);
  end

  assign clk_pre_nxt = (wr_w & hit_clk_pre) ? (wd & CLK_PRE_MASK) : clk_pre_r;
  assign match_lo_nxt = (wr_w & hit_match_lo) ? wd : match_lo_r;
  assign match_hi_nxt = (wr_w & hit_match_hi) ? wd : match_hi_r;

  // ----------------------------------------------------------------
  // read mux, captured in the setup cycle
  // ----------------------------------------------------------------
  wire [7:0] rd_count_lo = capture_read_select ? cap_lo_r : count_lo_r;
  wire [7:0] rd_count_hi = capture_read_select ? cap_hi_r : count_hi_r;
  wire [7:0] rd_byte = hit_match_lo ? match_lo_r :
                       hit_match_hi ? match_hi_r :
                       hit_count_lo ? rd_count_lo :
                       hit_count_hi ? rd_count_hi :
                       hit_run_flag ? run_flag_r :
                       hit_capture ? capture_r :
                       hit_clk_pre ? clk_pre_r : RST_BYTE;
  assign prdata_nxt = (setup_w & ~apb_i.pwrite) ? {24'h000000, rd_byte} : prdata_r;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // register bank and apb read data
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      match_lo_r <= RST_BYTE;
      match_hi_r <= RST_BYTE;
      run_flag_r <= RST_BYTE;
      capture_r <= RST_BYTE;
      clk_pre_r <= RST_BYTE;
      prdata_r <= 32'h00000000;
    end else begin
      match_lo_r <= match_lo_nxt;
      match_hi_r <= match_hi_nxt;
      run_flag_r <= run_flag_nxt;
      capture_r <= capture_nxt;
      clk_pre_r <= clk_pre_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // counters, buffers, captures, prescaler
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_lo_r <= RST_BYTE;
      count_hi_r <= RST_BYTE;
      buf_lo_r <= RST_BYTE;
      buf_hi_r <= RST_BYTE;
      cap_lo_r <= RST_BYTE;
      cap_hi_r <= RST_BYTE;
      pre_cnt_r <= RST_PRE;
    end else begin
      count_lo_r <= count_lo_nxt;
      count_hi_r <= count_hi_nxt;
      buf_lo_r <= buf_lo_nxt;
      buf_hi_r <= buf_hi_nxt;
      cap_lo_r <= cap_lo_nxt;
      cap_hi_r <= cap_hi_nxt;
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = access_w; // zero wait states
  assign pslverr_o = access_w & ~mapped_w; // unmapped address
  // one shared request line for all three sources
  assign irq_req_o = (split_mode_bit & upper_irq_enable & upper_match_flag) |
                     (main_irq_enable & main_match_flag) |
                     (capture_irq_enable & (lower_capture_flag | upper_capture_flag));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_read_setup_lo;
    setup_w && !apb_i.pwrite && hit_count_lo;
  endsequence
  sequence s_upper_stopped;
    split_mode_bit && !upper_run_bit;
  endsequence
  sequence s_lower_capture;
    lo_req;
  endsequence

  a_read_capture_sel: assert property (
    s_read_setup_lo ##0 capture_read_select |=> prdata_o[7:0] == $past(cap_lo_r))
    else $error("capture byte not returned on count address");
  a_upper_stop_hold: assert property (
    s_upper_stopped |=> count_hi_r == 8'h00 && buf_hi_r == $past(match_hi_r))
    else $error("stopped upper byte not at zero or buffer not tracking");
  a_upper_flag_set: assert property (
    set_upper_flag |=> upper_match_flag)
    else $error("upper match flag not set at zero");
  a_upper_irq_req: assert property (
    split_mode_bit && upper_irq_enable && upper_match_flag |-> irq_req_o)
    else $error("upper interrupt request missing");
  a_full_carry: assert property (
    !split_mode_bit && lo_ovf |=> count_hi_r == 8'($past(count_hi_r) + 8'h01))
    else $error("upper byte missed carry in 16-bit mode");
  a_main_stop_hold: assert property (
    !main_run_bit [*2] |-> count_lo_r == 8'h00 && buf_lo_r == $past(match_lo_r))
    else $error("stopped timer not at zero");
  a_main_flag_sticky: assert property (
    main_match_flag && !clr_main_flag |=> main_match_flag)
    else $error("main flag dropped without software clear");
  a_main_irq_req: assert property (
    main_irq_enable && main_match_flag |-> irq_req_o)
    else $error("main interrupt request missing");
  a_lower_capture: assert property (
    s_lower_capture |=> cap_lo_r == $past(count_lo_r) && lower_capture_flag)
    else $error("lower capture not taken or flag not set");
  a_upper_cap_full: assert property (
    !split_mode_bit && lo_req && !upper_capture_flag && !wr_capture |=> !upper_capture_flag)
    else $error("upper capture flag set in 16-bit mode");
  a_capture_irq_req: assert property (
    capture_irq_enable && (lower_capture_flag || upper_capture_flag) |-> irq_req_o)
    else $error("capture interrupt request missing");
  a_set_beats_clear: assert property (
    set_main_flag && clr_main_flag |=> main_match_flag)
    else $error("software clear beat hardware set");
  a_prescale_wrap: assert property (
    pre_match |=> pre_cnt_r == 4'h0)
    else $error("prescaler did not wrap at its period");
  a_system_clock_count: assert property (
    pre_run && clock_source_select == CKSEL_SYSTEM && pre_cnt_r != prescale_period
    |=> pre_cnt_r == 4'($past(pre_cnt_r) + 4'h1))
    else $error("prescaler not counting on system clock");

  // read path, live counter side and upper capture side
  a_read_count_lo: assert property (
    s_read_setup_lo ##0 !capture_read_select |=> prdata_o[7:0] == $past(count_lo_r))
    else $error("live lower count not returned");
  a_read_cap_hi: assert property (
    setup_w && !apb_i.pwrite && hit_count_hi && capture_read_select |=> prdata_o[7:0] == $past(cap_hi_r))
    else $error("upper capture byte not returned");

  // split mode upper byte, its flag and its capture, and the lower capture source
  a_split_upper_tick: assert property (
    split_mode_bit && hi_run && pre_match && !hi_match |=> count_hi_r == 8'($past(count_hi_r) + 8'h01))
    else $error("upper byte missed prescaler tick in split mode");
  a_upper_flag_sticky: assert property (
    upper_match_flag && !clr_upper_flag |=> upper_match_flag)
    else $error("upper flag dropped without software clear");
  a_upper_capture: assert property (
    split_mode_bit && hi_req |=> cap_hi_r == $past(count_hi_r) && upper_capture_flag)
    else $error("upper capture not taken or flag not set");
  a_upper_source: assert property (
    split_mode_bit && capture_source_select == 2'h3 && rise[4] |=> upper_capture_flag)
    else $error("upper capture missed its split source line");
  a_lower_source: assert property (
    capture_source_select == 2'h1 && rise[2] |=> lower_capture_flag)
    else $error("lower capture missed its source line");

  // event line choice, buffer reload and set priority
  a_event_line_hold: assert property (
    lo_run && clock_source_select == CKSEL_EVENT && !(event_line_select ? rise[3] : rise[2])
    |=> $stable(count_lo_r))
    else $error("lower byte moved without an event on the chosen line");
  a_lower_reload: assert property (
    lo_match |=> buf_lo_r == $past(match_lo_r))
    else $error("lower match buffer not reloaded at zero");
  a_upper_set_wins: assert property (
    set_upper_flag && clr_upper_flag |=> upper_match_flag)
    else $error("software clear beat upper flag set");
  a_capture_set_wins: assert property (
    set_lower_cap && clr_lower_cap |=> lower_capture_flag)
    else $error("software clear beat capture flag set");

endmodule : tcc_timer

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the timer control and capture block, driven over apb
// assumes tcc_pkg and tcc_timer are compiled first; one 250 mhz clock
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, observation and bookkeeping
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  tcc_apb_req_t apb_i = '0;
  tcc_pins_t pins_i = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_req_o;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] rd = '0; // data of the last transfer
  logic er = 1'b0; // error of the last transfer
  logic [31:0] regs [5] = '{ADDR_COUNT_LO, ADDR_COUNT_HI, ADDR_RUN_FLAG, ADDR_CAPTURE, ADDR_CLK_PRE};
  int lo_ln [4] = '{0, 2, 4, 5}; // lower capture line per source code
  int hi_ln [4] = '{1, 3, 5, 4}; // upper capture line per code, split mode
  logic [7:0] ck_cfg [4] = '{8'h40, 8'h60, 8'h80, 8'hC0}; // clock and event selections
  int ck_pin [4] = '{2, 3, 6, 7}; // pin that must tick
  int ck_bad [4] = '{3, 2, 7, 6}; // pin that must not tick

  always #2 clock_i = ~clock_i;

  tcc_timer dut (.clock_i(clock_i), .rstn_i(rstn_i), .apb_i(apb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pins_i(pins_i), .irq_req_o(irq_req_o));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict, the single end of the run
  task complete_run;
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is sampled high
  task xfer(input logic wr, input logic [31:0] adr, input logic [7:0] dat);
    int n;
    @(posedge clock_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: {24'h000000, dat}};
    @(posedge clock_i);
    apb_i.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 16) begin
      failures++;
      $display("wrong value at %0t: no pready", $time);
      complete_run();
    end else begin
      rd = prdata_o;
      er = pslverr_o;
      apb_i <= '0;
    end
  endtask : xfer

  task wr8(input logic [31:0] adr, input logic [7:0] dat);
    xfer(1'b1, adr, dat);
  endtask : wr8

  task rchk(input logic [31:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 8'h00);
    chk(rd, exp);
  endtask : rchk

  // one rising edge on a pin, long enough for the synchroniser
  task pulse(input int b);
    @(posedge clock_i);
    pins_i[b] <= 1'b1;
    repeat (3) @(posedge clock_i);
    pins_i[b] <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    // reset values, masks, refused and read-only accesses
    for (int i = 0; i < 5; i++) rchk(regs[i], 32'h0);
    wr8(ADDR_CAPTURE, 8'hFF);
    rchk(ADDR_CAPTURE, 32'h19);
    wr8(ADDR_CLK_PRE, 8'hFF);
    rchk(ADDR_CLK_PRE, 32'hEF);
    wr8(ADDR_RUN_FLAG, 8'h7B);
    rchk(ADDR_RUN_FLAG, 32'h39);
    xfer(1'b0, 32'h0, 8'h00);
    chk({er, rd[30:0]}, 32'h80000000);
    wr8(ADDR_COUNT_LO, 8'h5A);
    rchk(ADDR_COUNT_LO, 32'h0);
    wr8(ADDR_RUN_FLAG, 8'h00);
    wr8(ADDR_CLK_PRE, 8'h00);
    wr8(ADDR_CAPTURE, 8'h00);
    // split mode, both bytes run to match and set their flags
    wr8(ADDR_MATCH_LO, 8'h03);
    wr8(ADDR_MATCH_HI, 8'h03);
    wr8(ADDR_RUN_FLAG, 8'hB5);
    repeat (20) @(posedge clock_i);
    rchk(ADDR_RUN_FLAG, 32'hF7);
    chk(32'(irq_req_o), 32'h1);
    wr8(ADDR_RUN_FLAG, 8'h73);
    wr8(ADDR_RUN_FLAG, 8'h31);
    rchk(ADDR_RUN_FLAG, 32'h31);
    chk(32'(irq_req_o), 32'h0);
    rchk(ADDR_COUNT_LO, 32'h0);
    rchk(ADDR_COUNT_HI, 32'h0);
    // 16-bit mode, upper byte counts lower byte wraps
    wr8(ADDR_MATCH_LO, 8'hFF);
    wr8(ADDR_MATCH_HI, 8'hFF);
    wr8(ADDR_RUN_FLAG, 8'h04);
    repeat (600) @(posedge clock_i);
    xfer(1'b0, ADDR_COUNT_HI, 8'h00);
    chk(32'(rd inside {[1:3]}), 32'h1);
    // prescaler period of sixteen system clocks
    wr8(ADDR_RUN_FLAG, 8'h00);
    wr8(ADDR_CLK_PRE, 8'h0F);
    wr8(ADDR_RUN_FLAG, 8'h04);
    repeat (160) @(posedge clock_i);
    xfer(1'b0, ADDR_COUNT_LO, 8'h00);
    chk(32'(rd inside {[9:11]}), 32'h1);
    wr8(ADDR_CLK_PRE, 8'h00);
    // capture sources in split mode, lower byte running
    wr8(ADDR_RUN_FLAG, 8'h14);
    for (int c = 0; c < 4; c++) begin
      wr8(ADDR_CAPTURE, {3'h0, c[1:0], 3'h0});
      pulse(lo_ln[c]);
      rchk(ADDR_CAPTURE, {27'h0, c[1:0], 3'h2});
      pulse(hi_ln[c]);
      rchk(ADDR_CAPTURE, {27'h0, c[1:0], 3'h6});
    end
    // read select swaps counters for capture bytes
    wr8(ADDR_RUN_FLAG, 8'h18);
    xfer(1'b0, ADDR_COUNT_LO, 8'h00);
    chk(32'(rd != 32'h0), 32'h1);
    rchk(ADDR_COUNT_HI, 32'h0);
    wr8(ADDR_RUN_FLAG, 8'h10);
    rchk(ADDR_COUNT_LO, 32'h0);
    wr8(ADDR_CAPTURE, 8'h00);
    // 16-bit capture sets only the lower flag and raises the request
    wr8(ADDR_RUN_FLAG, 8'h04);
    wr8(ADDR_CAPTURE, 8'h01);
    pulse(0);
    rchk(ADDR_CAPTURE, 32'h3);
    chk(32'(irq_req_o), 32'h1);
    wr8(ADDR_CAPTURE, 8'h01);
    @(posedge clock_i);
    chk(32'(irq_req_o), 32'h0);
    // event line and aux oscillator sources each tick only on their own pin
    for (int k = 0; k < 4; k++) begin
      wr8(ADDR_RUN_FLAG, 8'h00);
      wr8(ADDR_CLK_PRE, ck_cfg[k]);
      wr8(ADDR_RUN_FLAG, 8'h04);
      repeat (3) pulse(ck_pin[k]);
      pulse(ck_bad[k]);
      rchk(ADDR_COUNT_LO, 32'h3);
    end
    // split mode low byte counts events directly, prescaler bypassed
    wr8(ADDR_RUN_FLAG, 8'h00);
    wr8(ADDR_CLK_PRE, 8'h4F);
    wr8(ADDR_RUN_FLAG, 8'h14);
    repeat (3) pulse(2);
    rchk(ADDR_COUNT_LO, 32'h3);
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
